// ### design/cache_cfg_pkg.sv
// Constants shared by the cache configuration and flush logic
package cache_cfg_pkg;
    localparam logic [31:0] addr_flush_control   = 32'h400c_3000;
    localparam logic [31:0] addr_line_config     = 32'h400c_3004;
    localparam logic [31:0] addr_way_config      = 32'h400c_3008;
    localparam logic [31:0] addr_cacheability    = 32'h400c_3020;
    localparam logic [31:0] addr_monitor_hits    = 32'h400c_3028;
    localparam logic [31:0] addr_monitor_misses  = 32'h400c_302c;
    localparam logic [31:0] addr_monitor_control = 32'h400c_3030;
    localparam logic [31:0] addr_monitor_period  = 32'h400c_3034;
    localparam logic [31:0] addr_monitor_limit   = 32'h400c_3038;

    localparam int flush_bit_pos        = 0;
    localparam int reserved_bit_pos     = 1;
    localparam int otp_cacheable_pos    = 11;
    localparam int flash_cacheable_pos  = 12;
    localparam int clock_gating_pos     = 10;
    localparam int data_write_en_pos    = 9;
    localparam int cacheable_length_w   = 9;

    localparam logic [1:0] line_8_bytes  = 2'h0;
    localparam logic [1:0] line_16_bytes = 2'h1;
    localparam logic [1:0] line_32_bytes = 2'h2;
    localparam logic [1:0] way_direct    = 2'h0;
    localparam logic [1:0] way_two       = 2'h1;
    localparam logic [1:0] way_four      = 2'h2;
    localparam logic [1:0] code_reserved = 2'h3;

    localparam logic [1:0] line_reset = line_8_bytes;
    localparam logic [1:0] way_reset  = way_four;
    localparam logic [8:0] length_reset = 9'h000;
    localparam logic [8:0] length_max   = 9'h1ff;

    localparam int flush_cycles_8k  = 32'h0000_0100;
    localparam int flush_cycles_16k = 32'h0000_0200;
    localparam int data_ram_kb_small = 8;
    localparam int data_ram_kb_large = 16;

    typedef enum logic [1:0] {
        flush_idle = 2'b01,
        flush_busy = 2'b10
    } flush_state_e;
endpackage

// ### design/cache_config_flush_control.sv
// Cache configuration registers, tag flush sequencing and cacheability control
//
// Added by the designer: strobed register access.
`timescale 1ns/100ps
`default_nettype none
module cache_config_flush_control
    import cache_cfg_pkg::*;
#(
    parameter int DATA_RAM_KB = data_ram_kb_large
) (
    input  wire logic        core_clk,
    input  wire logic        srst,
    input  wire logic [31:0] reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic      [31:0] reg_rdata,
    input  wire logic        otp_remapped,
    input  wire logic        flash_remapped,
    input  wire logic        lookup_hit_raw,
    output logic             lookup_hit,
    output logic             tag_invalidate,
    output logic             flush_busy_flag,
    output logic             flush_done,
    output logic       [5:0] line_bytes,
    output logic       [2:0] way_count,
    output logic             cache_enable,
    output logic             flash_cacheable,
    output logic             otp_cacheable,
    output logic             clock_gating_en,
    output logic             data_write_en,
    output logic       [8:0] cacheable_length
);
    initial begin
        if (DATA_RAM_KB != data_ram_kb_small && DATA_RAM_KB != data_ram_kb_large) begin
            $error("DATA_RAM_KB must be 8 or 16");
        end
    end

    localparam int flush_cycles =
        (DATA_RAM_KB == data_ram_kb_small) ? flush_cycles_8k : flush_cycles_16k;

    // Address decode
    wire sel_flush = (reg_addr == addr_flush_control);
    wire sel_line  = (reg_addr == addr_line_config);
    wire sel_way   = (reg_addr == addr_way_config);
    wire sel_cache = (reg_addr == addr_cacheability);

    wire wr_flush = reg_write && sel_flush;
    wire wr_line  = reg_write && sel_line;
    wire wr_way   = reg_write && sel_way;
    wire wr_cache = reg_write && sel_cache;

    wire flush_start = wr_flush && reg_wdata[flush_bit_pos];

    // Reserved bit is stored as written but has no effect on the logic
    logic       reserved_keep_zero;
    logic [1:0] line_code;
    logic [1:0] way_count_sel;
    logic       flash_cacheable_when_remapped;
    logic       otp_cacheable_when_remapped;
    logic       controller_clock_gating;
    logic       data_write_bit;
    logic       flush_busy;

    cfg_field_reg #(
        .RESET_VALUE (line_reset)
    ) u_line_field (
        .core_clk (core_clk),
        .srst     (srst),
        .wr_en    (wr_line),
        .wr_value (reg_wdata[1:0]),
        .value    (line_code)
    );

    cfg_field_reg #(
        .RESET_VALUE (way_reset)
    ) u_way_field (
        .core_clk (core_clk),
        .srst     (srst),
        .wr_en    (wr_way),
        .wr_value (reg_wdata[1:0]),
        .value    (way_count_sel)
    );

    tag_flush_timer #(
        .FLUSH_CYCLES (flush_cycles)
    ) u_flush_timer (
        .core_clk (core_clk),
        .srst     (srst),
        .start    (flush_start),
        .busy     (flush_busy),
        .done     (flush_done)
    );

    always_ff @(posedge core_clk) begin
        if (srst) begin
            reserved_keep_zero <= 1'b0;
        end else if (wr_flush) begin
            reserved_keep_zero <= reg_wdata[reserved_bit_pos];
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            flash_cacheable_when_remapped <= 1'b0;
            otp_cacheable_when_remapped   <= 1'b0;
            controller_clock_gating       <= 1'b0;
            data_write_bit                <= 1'b0;
            cacheable_length              <= length_reset;
        end else if (wr_cache) begin
            flash_cacheable_when_remapped <= reg_wdata[flash_cacheable_pos];
            otp_cacheable_when_remapped   <= reg_wdata[otp_cacheable_pos];
            controller_clock_gating       <= reg_wdata[clock_gating_pos];
            data_write_bit                <= reg_wdata[data_write_en_pos];
            // Nine bits top out at 511 units; a count of 512 cannot be stored
            cacheable_length <= reg_wdata[cacheable_length_w-1:0];
        end
    end

    // Decoded configuration
    wire [5:0] line_dec = (line_code == line_32_bytes) ? 6'd32 :
                          (line_code == line_16_bytes) ? 6'd16 : 6'd8;
    wire [2:0] way_dec  = (way_count_sel == way_four) ? 3'd4 :
                          (way_count_sel == way_two)  ? 3'd2 : 3'd1;

    wire enable_dec = (cacheable_length != length_reset);
    wire flash_dec  = enable_dec && flash_remapped && flash_cacheable_when_remapped;
    wire otp_dec    = enable_dec && otp_remapped && otp_cacheable_when_remapped;

    // Hits are suppressed both during the flush and in its issuing cycle
    wire hit_dec = lookup_hit_raw && enable_dec && !flush_busy && !flush_start;

    assign lookup_hit      = hit_dec;
    assign tag_invalidate  = flush_busy;
    assign flush_busy_flag = flush_busy;

    always_ff @(posedge core_clk) begin
        if (srst) begin
            line_bytes      <= 6'd8;
            way_count       <= 3'd4;
            cache_enable    <= 1'b0;
            flash_cacheable <= 1'b0;
            otp_cacheable   <= 1'b0;
            clock_gating_en <= 1'b0;
            data_write_en   <= 1'b0;
        end else begin
            line_bytes      <= line_dec;
            way_count       <= way_dec;
            cache_enable    <= enable_dec;
            flash_cacheable <= flash_dec;
            otp_cacheable   <= otp_dec;
            clock_gating_en <= controller_clock_gating;
            data_write_en   <= data_write_bit;
        end
    end

    // Read mux; flush bit never stored so it reads as zero
    wire [31:0] rd_flush = {30'h0000_0000, reserved_keep_zero, 1'b0};
    wire [31:0] rd_line  = {30'h0000_0000, line_code};
    wire [31:0] rd_way   = {30'h0000_0000, way_count_sel};
    wire [31:0] rd_cache = {19'h0_0000, flash_cacheable_when_remapped,
                            otp_cacheable_when_remapped, controller_clock_gating,
                            data_write_bit, cacheable_length};
    wire [31:0] rd_mux   = sel_flush ? rd_flush :
                           sel_line  ? rd_line  :
                           sel_way   ? rd_way   :
                           sel_cache ? rd_cache : 32'h0000_0000;

    always_ff @(posedge core_clk) begin
        if (srst) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_read) begin
            reg_rdata <= rd_mux;
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end
endmodule
`default_nettype wire

// ### design/cfg_field_reg.sv
// Two-bit configuration field that ignores the reserved code
`timescale 1ns/100ps
`default_nettype none
module cfg_field_reg
    import cache_cfg_pkg::*;
#(
    parameter logic [1:0] RESET_VALUE = 2'h0
) (
    input  wire logic       core_clk,
    input  wire logic       srst,
    input  wire logic       wr_en,
    input  wire logic [1:0] wr_value,
    output logic      [1:0] value
);
    wire take = wr_en && (wr_value != code_reserved);

    always_ff @(posedge core_clk) begin
        if (srst) begin
            value <= RESET_VALUE;
        end else if (take) begin
            value <= wr_value;
        end
    end
endmodule
`default_nettype wire

// ### design/tag_flush_timer.sv
// Counts out the fixed duration of a tag invalidation
`timescale 1ns/100ps
`default_nettype none
module tag_flush_timer
    import cache_cfg_pkg::*;
#(
    parameter int FLUSH_CYCLES = flush_cycles_16k
) (
    input  wire logic core_clk,
    input  wire logic srst,
    input  wire logic start,
    output logic      busy,
    output logic      done
);
    localparam int cnt_w = $clog2(FLUSH_CYCLES + 1);
    localparam logic [cnt_w-1:0] last_count = cnt_w'(FLUSH_CYCLES - 1);

    initial begin
        if (FLUSH_CYCLES < 2) begin
            $error("FLUSH_CYCLES must be at least 2");
        end
    end

    flush_state_e     state;
    flush_state_e     next_state;
    logic [cnt_w-1:0] count;
    wire              at_end = (count == last_count);

    always_comb begin
        next_state = state;
        case (state)
            flush_idle: begin
                if (start) begin
                    next_state = flush_busy;
                end
            end
            flush_busy: begin
                // A new start during a flush restarts it so no line escapes
                if (at_end && !start) begin
                    next_state = flush_idle;
                end
            end
            default: next_state = flush_idle;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            state <= flush_idle;
            count <= '0;
            done  <= 1'b0;
        end else begin
            state <= next_state;
            done  <= (state == flush_busy) && at_end && !start;
            if (start || state != flush_busy) begin
                count <= '0;
            end else begin
                count <= count + cnt_w'(1);
            end
        end
    end

    assign busy = (state == flush_busy);
endmodule
`default_nettype wire

// ### verification/cache_config_flush_control_tb_top.sv
// Self-checking bench for the cache configuration and flush block
`timescale 1ns/100ps
`default_nettype none
module cache_config_flush_control_tb_top;
    import cache_cfg_pkg::*;
    logic        core_clk = 1'b0, srst = 1'b1, reg_write = 1'b0, reg_read = 1'b0;
    logic        otp_remapped = 1'b0, flash_remapped = 1'b0, lookup_hit_raw, lookup_hit;
    logic        tag_invalidate, flush_done, cache_enable, flash_cacheable, otp_cacheable, gate_en;
    logic        busy_flag, data_wr_en;
    logic [31:0] reg_addr = 32'h0000_0000, reg_wdata = 32'h0000_0000, reg_rdata;
    logic [31:0] seed = 32'h3465_2b1e;
    logic  [5:0] line_bytes;
    logic  [2:0] way_count;
    logic  [8:0] cacheable_length;
    logic [15:0] hit_count;
    int          n_mismatch = 0, samples_checked = 0;
    always #2.5 core_clk = ~core_clk;
    cache_config_flush_control #(.DATA_RAM_KB(data_ram_kb_small)) cache_config_flush_control_inst (
        .core_clk, .srst, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .otp_remapped,
        .flash_remapped, .lookup_hit_raw, .lookup_hit, .tag_invalidate, .flush_busy_flag(busy_flag),
        .flush_done, .line_bytes, .way_count, .cache_enable, .flash_cacheable, .otp_cacheable,
        .clock_gating_en(gate_en), .data_write_en(data_wr_en), .cacheable_length);
    core_fetch_model core_fetch_model_inst (
        .core_clk, .srst, .lookup_hit, .lookup_hit_raw, .hit_count);
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] exp, input string what);
        @(posedge core_clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_read <= 1'b0;
        #1 chk(what, exp, reg_rdata);
    endtask
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        logic [31:0] d;
        logic  [1:0] c, w, line_c, way_c;
        logic [15:0] h;
        int          n;
        repeat (20) @(posedge core_clk);
        srst <= 1'b0;
        rd(addr_flush_control, 32'h0, "flush_control");
        rd(addr_line_config, 32'h0, "line_config");
        rd(addr_way_config, 32'h2, "way_config");
        rd(addr_cacheability, 32'h0, "cacheability");
        rd(32'h400c_3050, 32'h0, "unmapped");
        line_c = line_reset;
        way_c = way_reset;
        // Each code once, then random; reserved bits above the field are written too
        for (int i = 0; i < 24; i++) begin
            c = (i < 4) ? 2'(i) : seed[1:0];
            w = ~c;
            wr(addr_line_config, {seed[31:2], c});
            if (c == line_8_bytes) wr(addr_flush_control, 32'h0000_0001);
            if (c != code_reserved) line_c = c;
            if (w != code_reserved && w < way_c) wr(addr_flush_control, 32'h0000_0001);
            wr(addr_way_config, {seed[31:2], w});
            if (w != code_reserved) way_c = w;
            repeat (2) @(posedge core_clk);
            #1 chk("line_bytes", 32'h8 << line_c, line_bytes);
            chk("way_count", 32'h1 << way_c, way_count);
            rd(addr_line_config, line_c, "line_config");
            rd(addr_way_config, way_c, "way_config");
            seed = xs(seed);
        end
        for (int i = 0; i < 12; i++) begin
            d = seed;
            if (i == 0) d[8:0] = 9'h000;
            if (i == 1) d[21:11] = 11'h7ff;
            @(posedge core_clk);
            flash_remapped <= d[20];
            otp_remapped <= d[21];
            wr(addr_cacheability, d);
            repeat (2) @(posedge core_clk);
            #1 chk("cache_enable", d[8:0] != 9'h000, cache_enable);
            chk("flash_cacheable", d[12] && d[8:0] != 9'h000 && d[20], flash_cacheable);
            chk("otp_cacheable", d[11] && d[8:0] != 9'h000 && d[21], otp_cacheable);
            chk("length", d[8:0], cacheable_length);
            chk("gating", d[10], gate_en);
            chk("data_write_en", d[9], data_wr_en);
            rd(addr_cacheability, d & 32'h0000_1fff, "cacheability");
            seed = xs(seed);
        end
        // Gating off and 8-byte lines before flushing; flush restarted mid-way
        wr(addr_cacheability, 32'h0000_0001);
        wr(addr_line_config, 32'h0000_0000);
        wr(addr_flush_control, 32'h0000_0001);
        rd(addr_flush_control, 32'h0, "flush_busy_read");
        repeat (90) @(posedge core_clk);
        wr(addr_flush_control, 32'h0000_0001);
        #1 h = hit_count;
        n = 0;
        while (flush_done !== 1'b1 && n < 1000) begin
            chk("tag_invalidate", 1, tag_invalidate);
            chk("flush_busy_flag", 1, busy_flag);
            chk("lookup_hit", 0, lookup_hit);
            @(posedge core_clk);
            #1 n++;
        end
        if (n >= 1000) n_mismatch++;
        chk("flush_cycles", flush_cycles_8k, n);
        chk("hits_in_flush", h, hit_count);
        @(posedge core_clk);
        #1 chk("flush_done_pulse", 0, flush_done);
        chk("busy_after", 0, busy_flag);
        repeat (10) @(posedge core_clk);
        #1 chk("hits_after", 1, hit_count > h);
        end_sim();
    end
endmodule
`default_nettype wire

// ### verification/core_fetch_model.sv
// Code fetch side: raw tag hits offered and a count of hits granted
`timescale 1ns/100ps
`default_nettype none
module core_fetch_model (
    input  wire logic        core_clk,
    input  wire logic        srst,
    input  wire logic        lookup_hit,
    output logic             lookup_hit_raw,
    output logic      [15:0] hit_count
);
    logic [2:0] phase;
    always_ff @(posedge core_clk) begin
        if (srst) begin
            phase     <= 3'h0;
            hit_count <= 16'h0000;
        end else begin
            phase     <= phase + 3'h1;
            hit_count <= hit_count + {15'h0000, lookup_hit};
        end
    end
    // Raw hit drops once in eight so a stuck hit mask still shows
    assign lookup_hit_raw = (phase != 3'h0);
endmodule
`default_nettype wire

// ### verification/flush_ctrl_asserts.sv
// Port checker for the cache configuration and flush block
`timescale 1ns/100ps
`default_nettype none
module flush_ctrl_checker
    import cache_cfg_pkg::*;
#(
    parameter int DATA_RAM_KB = data_ram_kb_large
) (
    input wire logic        core_clk,
    input wire logic        srst,
    input wire logic [31:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_write,
    input wire logic        reg_read,
    input wire logic [31:0] reg_rdata,
    input wire logic        otp_remapped,
    input wire logic        flash_remapped,
    input wire logic        lookup_hit,
    input wire logic        tag_invalidate,
    input wire logic        flush_done,
    input wire logic  [5:0] line_bytes,
    input wire logic  [2:0] way_count,
    input wire logic        cache_enable,
    input wire logic        flash_cacheable,
    input wire logic        otp_cacheable,
    input wire logic  [8:0] cacheable_length
);
    localparam int n_flush =
        (DATA_RAM_KB == data_ram_kb_small) ? flush_cycles_8k : flush_cycles_16k;
    logic [10:0] since_start;
    wire         flush_go = reg_write && reg_addr == addr_flush_control && reg_wdata[0];
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);
    sequence flush_req;
        flush_go;
    endsequence
    sequence wr_to(a);
        reg_write && reg_addr == a;
    endsequence
    // A restart reloads the count, as the flush logic does
    always_ff @(posedge core_clk) begin
        if (srst) since_start <= 11'h000;
        else if (flush_go) since_start <= 11'h001;
        else if (since_start != 11'h7ff) since_start <= since_start + 11'h001;
    end
    a_flush_start: assert property (flush_req |=> tag_invalidate)
        else $error("flush did not start");
    a_flush_length: assert property (flush_done |-> since_start == n_flush + 1)
        else $error("flush length wrong");
    a_hit_masked: assert property ((flush_go || tag_invalidate) |-> !lookup_hit)
        else $error("hit during flush");
    // The registered enable trails the length by a cycle, so hits follow the length itself
    a_hit_needs_en: assert property (lookup_hit |-> cacheable_length != 9'h000)
        else $error("hit with cache disabled");
    a_flush_reads_zero: assert property (wr_to(addr_flush_control) or
        (reg_read && reg_addr == addr_flush_control) |=> !reg_rdata[0])
        else $error("flush bit read back one");
    a_line_map: assert property (wr_to(addr_line_config) ##0 reg_wdata[1:0] != code_reserved
        |=> ##1 line_bytes == (6'h08 << $past(reg_wdata[1:0], 2))) else $error("line size wrong");
    a_line_hold: assert property (wr_to(addr_line_config) ##0 reg_wdata[1:0] == code_reserved
        |=> ##1 $stable(line_bytes)) else $error("reserved line code took effect");
    a_way_map: assert property (wr_to(addr_way_config) ##0 reg_wdata[1:0] != code_reserved
        |=> ##1 way_count == (3'h1 << $past(reg_wdata[1:0], 2))) else $error("way count wrong");
    a_enable_len: assert property (wr_to(addr_cacheability)
        |=> ##1 cache_enable == ($past(reg_wdata[8:0], 2) != 9'h000)) else $error("enable wrong");
    a_flash_cache: assert property (wr_to(addr_cacheability) |=> ##1 flash_cacheable ==
        ($past(reg_wdata[12], 2) && cache_enable && flash_remapped))
        else $error("flash cache wrong");
    a_otp_cache: assert property (wr_to(addr_cacheability) |=> ##1 otp_cacheable ==
        ($past(reg_wdata[11], 2) && cache_enable && otp_remapped))
        else $error("otp cache wrong");
endmodule
bind cache_config_flush_control flush_ctrl_checker #(.DATA_RAM_KB(DATA_RAM_KB)) flush_ctrl_checker_inst (
    .core_clk, .srst, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .otp_remapped,
    .flash_remapped, .lookup_hit, .tag_invalidate, .flush_done, .line_bytes, .way_count,
    .cache_enable, .flash_cacheable, .otp_cacheable, .cacheable_length
);
`default_nettype wire
